// ===== rtl/rcl_decoder.sv
// decoder and executor for return-from-interrupt, return-with-literal and load-config
// Behaviour
// [RULE_01] return-from-interrupt pops stack, top value goes to the program counter, one word
// [RULE_02] return-from-interrupt sets global interrupt enable, bit 7; no status flags change
// [RULE_03] return-from-interrupt takes two instruction cycles
// [RULE_04] load-config copies accumulator into timer config register, one cycle, flags kept
// [RULE_05] config register is also read and written through data-memory addressing
// [RULE_06] software should prefer direct addressing over the load-config opcode
// [RULE_07] return-with-literal loads literal into accumulator, pops stack, two cycles
// [RULE_08] start-up timer holds the core in reset for 1024 oscillator periods
module rcl_decoder
	import rcl_pkg::*;
#(
	parameter int OST_COUNT = rcl_pkg::OST_PERIODS
) (
	input wire logic clock_in, // core clock
	input wire logic rst_in, // synchronous reset, active high
	input wire logic osc_tick_in, // one pulse per oscillator period
	input wire logic instr_valid_in, // fetched word present
	input wire logic [rcl_pkg::WORD_W-1:0] instr_in, // fetched word
	input wire logic [rcl_pkg::PC_W-1:0] stack_top_value_in, // top of hardware stack
	input wire logic [rcl_pkg::DATA_W-1:0] acc_in, // working accumulator
	input wire logic cfg_wr_in, // data-memory write to config register
	input wire logic [rcl_pkg::DATA_W-1:0] cfg_wdata_in, // data-memory write value
	input wire logic irq_ctl_wr_in, // data-memory write to interrupt control
	input wire logic [rcl_pkg::DATA_W-1:0] irq_ctl_wdata_in, // write value
	output logic core_hold_out, // core held in reset
	output logic busy_out, // second cycle of a two-cycle op
	output logic stack_pop_out, // pop pulse
	output logic pc_load_out, // load program counter pulse
	output logic [rcl_pkg::PC_W-1:0] pc_value_out, // value for program counter
	output logic acc_load_out, // load accumulator pulse
	output logic [rcl_pkg::DATA_W-1:0] acc_value_out, // value for accumulator
	output logic [rcl_pkg::DATA_W-1:0] cfg_reg_out, // timer/watchdog config register
	output logic [rcl_pkg::DATA_W-1:0] interrupt_control_reg_out // interrupt control register
);
	initial begin
		if (OST_COUNT < 1) $error("OST_COUNT must be positive");
	end

	function automatic logic is_ret_lit(input logic [WORD_W-1:0] w);
		return (w & RETLIT_MASK) == RETLIT_MATCH;
	endfunction : is_ret_lit

	// ********************
	// start-up hold
	// ********************
	rcl_ost_if ost_if ();
	logic osc_s1_reg;
	logic osc_s2_reg;
	logic osc_s3_reg;
	assign ost_if.osc_tick = osc_s2_reg & ~osc_s3_reg;

	rcl_ost #(
		.PERIODS(OST_COUNT)
	) u_ost (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.ost(ost_if.timer)
	);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
			osc_s3_reg <= 1'b0;
		end else begin
			osc_s1_reg <= osc_tick_in;
			osc_s2_reg <= osc_s1_reg;
			osc_s3_reg <= osc_s2_reg;
		end
	end

	// ********************
	// decode and execute
	// ********************
	rcl_state_e state_reg;
	rcl_state_e state_next;
	logic hold_reg;
	logic hold_next;
	logic busy_reg;
	logic busy_next;
	logic pop_reg;
	logic pop_next;
	logic pc_ld_reg;
	logic pc_ld_next;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic acc_ld_reg;
	logic acc_ld_next;
	logic [DATA_W-1:0] accv_reg;
	logic [DATA_W-1:0] accv_next;
	logic [DATA_W-1:0] cfg_reg;
	logic [DATA_W-1:0] cfg_next;
	logic [DATA_W-1:0] ictl_reg;
	logic [DATA_W-1:0] ictl_next;

	always_comb begin
		state_next = state_reg;
		hold_next = ost_if.hold; // see [RULE_08]
		busy_next = 1'b0;
		pop_next = 1'b0;
		pc_ld_next = 1'b0;
		pc_next = pc_reg;
		acc_ld_next = 1'b0;
		accv_next = accv_reg;
		cfg_next = cfg_reg;
		ictl_next = ictl_reg;
		// direct data-memory access keeps the register usable without the legacy opcode
		if (cfg_wr_in) begin
			cfg_next = cfg_wdata_in; // see [RULE_05]
		end
		if (irq_ctl_wr_in) begin
			ictl_next = irq_ctl_wdata_in;
		end
		if (ost_if.hold) begin
			state_next = RCL_IDLE;
		end else begin
			case (state_reg)
				RCL_IDLE: begin
					if (instr_valid_in) begin
						if (instr_in == OP_RET_IRQ) begin
							pop_next = 1'b1; // see [RULE_01]
							pc_ld_next = 1'b1;
							pc_next = stack_top_value_in;
							ictl_next[IRQ_ENABLE_BIT] = 1'b1; // see [RULE_02]
							busy_next = 1'b1; // see [RULE_03]
							state_next = RCL_SECOND;
						end else if (is_ret_lit(instr_in)) begin
							pop_next = 1'b1; // see [RULE_07]
							pc_ld_next = 1'b1;
							pc_next = stack_top_value_in;
							acc_ld_next = 1'b1;
							accv_next = instr_in[DATA_W-1:0];
							busy_next = 1'b1;
							state_next = RCL_SECOND;
						end else if (instr_in == OP_LOAD_CFG) begin
							cfg_next = acc_in; // see [RULE_04]
						end
					end
				end
				RCL_SECOND: begin
					// second cycle flushes the fetched word; nothing executes
					state_next = RCL_IDLE;
				end
				default: begin
					state_next = RCL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_reg <= RCL_IDLE;
			hold_reg <= 1'b1;
			busy_reg <= 1'b0;
			pop_reg <= 1'b0;
			pc_ld_reg <= 1'b0;
			pc_reg <= '0;
			acc_ld_reg <= 1'b0;
			accv_reg <= '0;
			cfg_reg <= CFG_RESET;
			ictl_reg <= IRQ_CTL_RESET;
		end else begin
			state_reg <= state_next;
			hold_reg <= hold_next;
			busy_reg <= busy_next;
			pop_reg <= pop_next;
			pc_ld_reg <= pc_ld_next;
			pc_reg <= pc_next;
			acc_ld_reg <= acc_ld_next;
			accv_reg <= accv_next;
			cfg_reg <= cfg_next;
			ictl_reg <= ictl_next;
		end
	end

	assign core_hold_out = hold_reg;
	assign busy_out = busy_reg;
	assign stack_pop_out = pop_reg;
	assign pc_load_out = pc_ld_reg;
	assign pc_value_out = pc_reg;
	assign acc_load_out = acc_ld_reg;
	assign acc_value_out = accv_reg;
	assign cfg_reg_out = cfg_reg;
	assign interrupt_control_reg_out = ictl_reg;
endmodule : rcl_decoder

// ===== rtl/rcl_ost.sv
// oscillator start-up timer: holds the core in reset for a count of oscillator periods
module rcl_ost #(
	parameter int PERIODS = rcl_pkg::OST_PERIODS
) (
	input wire logic clock_in, // core clock
	input wire logic rst_in, // synchronous reset
	rcl_ost_if.timer ost // tick in, hold out
);
	import rcl_pkg::*;
	initial begin
		if (PERIODS < 1 || PERIODS >= (1 << OST_CNT_W)) $error("PERIODS out of range");
	end
	logic [OST_CNT_W-1:0] cnt_reg;
	logic [OST_CNT_W-1:0] cnt_next;
	logic hold_reg;
	logic hold_next;
	always_comb begin
		cnt_next = cnt_reg;
		hold_next = hold_reg;
		if (hold_reg && ost.osc_tick) begin
			cnt_next = cnt_reg + 1'b1;
			if (cnt_reg == OST_CNT_W'(PERIODS - 1)) begin
				hold_next = 1'b0; // see [RULE_08]
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cnt_reg <= '0;
			hold_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			hold_reg <= hold_next;
		end
	end
	assign ost.hold = hold_reg;
endmodule : rcl_ost

// ===== rtl/rcl_ost_if.sv
// interface: start-up hold between top and timer
interface rcl_ost_if;
	logic osc_tick;
	logic hold;
	modport timer (input osc_tick, output hold);
	modport core (output osc_tick, input hold);
endinterface : rcl_ost_if

// ===== rtl/rcl_pkg.sv
// package: constants for the return and configuration-load decoder
package rcl_pkg;
	localparam int WORD_W = 14;
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	localparam logic [13:0] OP_RET_IRQ = 14'h0009;
	localparam logic [13:0] OP_LOAD_CFG = 14'h0062;
	localparam logic [13:0] RETLIT_MASK = 14'h3C00;
	localparam logic [13:0] RETLIT_MATCH = 14'h3400;
	localparam int IRQ_ENABLE_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'hFF;
	localparam logic [7:0] IRQ_CTL_RESET = 8'h00;
	localparam int OST_PERIODS = 1024;
	localparam int OST_CNT_W = 11;
	localparam logic [1:0] MULTI_CYCLES = 2'h2;
	typedef enum logic [1:0] {
		RCL_IDLE,
		RCL_SECOND
	} rcl_state_e;
endpackage : rcl_pkg

// ===== verification/rcl_fetch_model.sv
// fetch-side model: presents instruction words and the stack top
module rcl_fetch_model
	import rcl_pkg::*;
(
	input logic clock_in, // core clock
	output logic instr_valid_out, // word present
	output logic [WORD_W-1:0] instr_out, // word
	output logic [PC_W-1:0] top_out // stack top
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// drivers
	// ****
	initial begin
		instr_valid_out = 1'b0;
		instr_out = '0;
		top_out = '0;
	end
	task automatic issue(input logic [WORD_W-1:0] w, input logic [PC_W-1:0] t);
		@(negedge clock_in);
		instr_valid_out = 1'b1;
		instr_out = w;
		top_out = t;
	endtask : issue
	// released lines flip so a stale word never looks live
	task automatic idle();
		@(negedge clock_in);
		instr_valid_out = 1'b0;
		instr_out = ~instr_out;
		top_out = ~top_out;
	endtask : idle
endmodule : rcl_fetch_model

// ===== verification/rcl_monitor.sv
// checker: port assertions for the return and config-load decoder
module rcl_monitor
	import rcl_pkg::*;
(
	input logic clock_in, // clock
	input logic rst_in, // reset
	input logic instr_valid_in, // word present
	input logic [WORD_W-1:0] instr_in, // word
	input logic [PC_W-1:0] stack_top_value_in, // stack top
	input logic [DATA_W-1:0] acc_in, // accumulator
	input logic cfg_wr_in, // config write
	input logic [DATA_W-1:0] cfg_wdata_in, // write data
	input logic core_hold_out, // hold
	input logic busy_out, // busy
	input logic stack_pop_out, // pop
	input logic pc_load_out, // pc load
	input logic [PC_W-1:0] pc_value_out, // pc value
	input logic acc_load_out, // acc load
	input logic [DATA_W-1:0] acc_value_out, // literal
	input logic [DATA_W-1:0] cfg_reg_out, // config
	input logic [DATA_W-1:0] interrupt_control_reg_out // irq control
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// assertions
	// ****
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	wire take = instr_valid_in && !busy_out && !core_hold_out;
	wire t_cfg = take && instr_in == OP_LOAD_CFG;
	sequence s_ret; take && instr_in == OP_RET_IRQ; endsequence
	sequence s_lit; take && (instr_in & RETLIT_MASK) == RETLIT_MATCH; endsequence
	sequence s_two; busy_out ##1 !busy_out && !stack_pop_out; endsequence
	ret_pop_a: assert property (s_ret |=> stack_pop_out && pc_load_out
		&& pc_value_out == $past(stack_top_value_in)) else $error("return pop wrong");
	enable_set_a: assert property (s_ret |=> interrupt_control_reg_out[IRQ_ENABLE_BIT])
		else $error("enable not set");
	two_cycle_a: assert property (s_ret |=> s_two) else $error("return length wrong");
	cfg_load_a: assert property (t_cfg |=> cfg_reg_out == $past(acc_in))
		else $error("config load wrong");
	// the timer's own hold drops a cycle before core_hold_out, so a load word may be taken then
	cfg_write_a: assert property (cfg_wr_in && !(instr_valid_in && !busy_out
		&& instr_in == OP_LOAD_CFG) |=>
		cfg_reg_out == $past(cfg_wdata_in)) else $error("config write lost");
	lit_load_a: assert property (s_lit |=> acc_load_out && stack_pop_out
		&& acc_value_out == $past(instr_in[7:0]) ##0 s_two) else $error("literal wrong");
	hold_reset_a: assert property (disable iff (1'b0) rst_in |=> core_hold_out
		&& cfg_reg_out == CFG_RESET) else $error("hold missing");
	pop_pair_a: assert property (stack_pop_out |-> pc_load_out && $past(instr_valid_in))
		else $error("stray pop");
endmodule : rcl_monitor
bind rcl_decoder rcl_monitor i_mon (.*);

// ===== verification/tb_return_and_config_load_ops.sv
// testbench: scenarios for the return and config-load decoder
module tb_return_and_config_load_ops;
	timeunit 1ns;
	timeprecision 1ps;
	import rcl_pkg::*;
	// ****
	// bench
	// ****
	logic clock_in = 1'b0, rst_in = 1'b1, osc = 1'b0, vld, cfg_wr = 1'b0, irq_wr = 1'b0;
	logic hold, busy;
	logic [WORD_W-1:0] instr;
	logic [PC_W-1:0] stack_top, pc_v;
	logic [DATA_W-1:0] acc = 8'h5A, cfg_wd = 8'h00, irq_wd = 8'h00, acc_v, cfg, irq;
	int mismatches = 0, checked = 0, cycles = 0;
	rcl_fetch_model i_fetch (.clock_in(clock_in), .instr_valid_out(vld), .instr_out(instr),
		.top_out(stack_top));
	rcl_decoder #(.OST_COUNT(4)) i_dut (.clock_in(clock_in), .rst_in(rst_in), .osc_tick_in(osc),
		.instr_valid_in(vld), .instr_in(instr), .stack_top_value_in(stack_top), .acc_in(acc),
		.cfg_wr_in(cfg_wr), .cfg_wdata_in(cfg_wd), .irq_ctl_wr_in(irq_wr),
		.irq_ctl_wdata_in(irq_wd), .core_hold_out(hold), .busy_out(busy), .stack_pop_out(),
		.pc_load_out(), .pc_value_out(pc_v), .acc_load_out(), .acc_value_out(acc_v),
		.cfg_reg_out(cfg), .interrupt_control_reg_out(irq));
	initial forever #2 clock_in = ~clock_in;
	initial forever begin
		repeat (2) @(negedge clock_in);
		osc = ~osc;
	end
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task automatic t_hold();
		repeat (8) @(negedge clock_in);
		chk(hold === 1'b1 && irq === IRQ_CTL_RESET, "early release");
		repeat (20) @(negedge clock_in);
		chk(hold === 1'b0, "never released");
		$display("hold done");
	endtask : t_hold
	task automatic t_ret();
		logic [DATA_W-1:0] c = cfg;
		i_fetch.issue(OP_RET_IRQ, 13'h1ABC);
		i_fetch.issue(OP_LOAD_CFG, 13'h0000);
		i_fetch.idle();
		chk(pc_v === 13'h1ABC && irq[IRQ_ENABLE_BIT] === 1'b1, "return");
		chk(cfg === c, "taken while busy");
		$display("return done");
	endtask : t_ret
	task automatic t_lit();
		logic [WORD_W-1:0] w [2] = '{14'h3400, 14'h37FF};
		foreach (w[i]) begin
			i_fetch.issue(w[i], PC_W'(i + 5));
			i_fetch.idle();
			chk(acc_v === w[i][7:0] && pc_v === PC_W'(i + 5), "literal");
		end
		$display("literal done");
	endtask : t_lit
	task automatic t_cfg();
		acc = 8'h3C;
		i_fetch.issue(OP_LOAD_CFG, '0);
		i_fetch.idle();
		chk(cfg === 8'h3C, "config load");
		cfg_wd = 8'h81;
		cfg_wr = 1'b1;
		@(negedge clock_in);
		cfg_wr = 1'b0;
		chk(cfg === 8'h81 && irq === 8'h80, "direct write");
		// clear the enable so the closing return has to set it again
		irq_wd = 8'h00;
		irq_wr = 1'b1;
		@(negedge clock_in);
		irq_wr = 1'b0;
		chk(irq === 8'h00 && cfg === 8'h81, "control write");
		$display("config done");
	endtask : t_cfg
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		repeat (20) @(negedge clock_in);
		rst_in = 1'b0;
		t_hold();
		t_ret();
		t_lit();
		t_cfg();
		t_ret();
		end_sim();
	end
endmodule : tb_return_and_config_load_ops
